//--- verilog/spictl_defines.svh
// register offsets, field positions, reset values and timing counts for the serial control block
`ifndef SPICTL_DEFINES_SVH
`define SPICTL_DEFINES_SVH

`define SPICTL_ADDR_W 3
`define SPICTL_ADDR_CTL_ONE 3'h0
`define SPICTL_ADDR_CTL_TWO 3'h1
`define SPICTL_ADDR_BIT_RATE 3'h2
`define SPICTL_ADDR_STATUS 3'h3
`define SPICTL_ADDR_EVT_STATUS 3'h4
`define SPICTL_ADDR_EVT_MASK 3'h5

`define SPICTL_C1_ENABLE 6
`define SPICTL_C1_MASTER 4
`define SPICTL_C1_SEL_OE 1
`define SPICTL_C2_FAULT_EN 4
`define SPICTL_C2_DRIVE_EN 3
`define SPICTL_C2_HALT_WAIT 1
`define SPICTL_C2_SINGLE 0
`define SPICTL_ST_RX_FULL 7
`define SPICTL_ST_TX_EMPTY 5
`define SPICTL_ST_FAULT 4
`define SPICTL_EVT_FAULT 0
`define SPICTL_EVT_HALT 1

`define SPICTL_RST_CTL_ONE 8'h00
`define SPICTL_RST_CTL_TWO 8'h00
`define SPICTL_RST_BIT_RATE 8'h00
`define SPICTL_RST_EVT 2'h0

`define SPICTL_CLK_PERIOD_NS 5
`define SPICTL_SYNC_STAGES 3

`endif

//--- verilog/spictl_pkg.sv
// types shared by the serial control block files
`include "spictl_defines.svh"
package spictl_pkg;

    typedef struct packed {
        logic fault_detect_enable;
        logic shared_pin_drive_enable;
        logic halt_in_wait;
        logic single_wire_select;
    } spictl_ctl_two_s;

    typedef struct packed {
        logic enable;
        logic master_select;
        logic select_output_enable;
    } spictl_ctl_one_s;

    typedef struct packed {
        logic [2:0] prescale_field;
        logic [2:0] rate_divisor_field;
    } spictl_rate_s;

    // one pin seen from the block: output level and active-low enable
    typedef struct packed {
        logic level;
        logic oe_n;
    } spictl_pin_s;

    typedef struct packed {
        logic [`SPICTL_ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } spictl_bus_s;

endpackage

//--- verilog/spictl_sync.sv
// three-stage input synchroniser, change accepted once stages two and three agree
`timescale 1ns/10ps
module spictl_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic clk_en_in,
    input wire logic async_in,
    output logic sync_out
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // first stage feeds only the second
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s1_reg <= RESET_VAL;
            s2_reg <= RESET_VAL;
            s3_reg <= RESET_VAL;
        end else if (clk_en_in) begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync_out <= RESET_VAL;
        end else if (clk_en_in && (s2_reg == s3_reg)) begin
            sync_out <= s3_reg;
        end
    end
endmodule

//--- verilog/spictl_top.sv
// serial interface pin control, baud rate generator and status registers
//
// Operation
// R01 - Bits 7, 6, 5 and 2 of the second control register always read as zero.
// R02 - As slave the select pin is always the active-low select input, whatever the fault enable says.
// R03 - As master with fault enable clear the select pin is released to general-purpose use.
// R04 - As master with fault enable set the select pin is either the fault input or an automatic select output.
// R05 - In single-wire mode the shared pin is driven when the drive enable is one and receives when it is zero. As slave the code also needs select low.
// R06 - Outside single-wire mode the drive enable bit has no effect.
// R07 - Serial clocks keep running in wait unless halt in wait is set, which stops them on wait entry.
// R08 - Single-wire data uses the slave-out pin as slave and the master-out pin as master.
// R09 - With single-wire mode off, separate pins carry data in and data out.
// R10 - The bit rate register may be read and written at any time.
// R11 - The prescaler divides the bus clock by the prescale field plus one, 1 to 8.
// R12 - The divider divides the prescaler output by two to the power of the rate field plus one, 2 to 256.
// R13 - Status bits 6, 3, 2, 1 and 0 read zero and writes to status do nothing.
// R14 - As master with fault enable set the select pin is the fault input when select output enable is zero, else output.
// R15 - The fault flag sets when master, fault enable set, select output off and the select input is low.
// R16 - The master bit clock is the bus clock divided by the prescale factor times the rate divisor.
`timescale 1ns/10ps
`include "spictl_defines.svh"
module spictl_top (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic clk_en_in,
    input wire spictl_pkg::spictl_bus_s bus_in,
    output logic [7:0] rd_data_out,
    output logic irq_out,
    input wire logic wait_mode_in,
    input wire logic rx_full_in,
    input wire logic tx_empty_in,
    input wire logic transfer_active_in,
    input wire logic shift_data_in,
    output logic rx_bit_out,
    output logic slave_selected_out,
    output logic bit_clk_out,
    output logic bit_tick_out,
    output logic clocks_running_out,
    output logic ss_gpio_release_out,
    input wire logic ss_in,
    output spictl_pkg::spictl_pin_s ss_pin_out,
    input wire logic mosi_in,
    output spictl_pkg::spictl_pin_s mosi_pin_out,
    input wire logic miso_in,
    output spictl_pkg::spictl_pin_s miso_pin_out
);
    import spictl_pkg::*;

    spictl_ctl_one_s ctl_one_reg;
    spictl_ctl_two_s ctl_two_reg;
    spictl_rate_s bit_rate_reg;
    logic fault_flag_reg;
    logic fault_armed_reg;
    logic [1:0] evt_status_reg;
    logic [1:0] evt_mask_reg;
    logic wait_prev_reg;
    logic [2:0] pre_cnt_reg;
    logic [6:0] div_cnt_reg;
    logic [7:0] div_limit;
    logic ss_sync;
    logic mosi_sync;
    logic miso_sync;
    logic is_master;
    logic is_slave;
    logic fault_cond;
    logic halted;
    logic baud_run;
    logic pre_wrap;
    logic div_wrap;
    logic wr_ctl_one;
    logic wr_ctl_two;
    logic wr_bit_rate;
    logic wr_evt_status;
    logic wr_evt_mask;
    logic rd_status;
    logic halt_event;
    logic [7:0] ctl_two_view;
    logic [7:0] bit_rate_view;
    logic [7:0] status_view;
    logic [7:0] rd_data_next;
    spictl_pin_s ss_pin_next;
    spictl_pin_s mosi_pin_next;
    spictl_pin_s miso_pin_next;
    logic gpio_release_next;
    logic rx_bit_next;
    logic selected_next;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    spictl_sync #(.RESET_VAL(1'b1)) u_ss_sync (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .clk_en_in(clk_en_in),
        .async_in(ss_in),
        .sync_out(ss_sync)
    );

    spictl_sync #(.RESET_VAL(1'b0)) u_mosi_sync (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .clk_en_in(clk_en_in),
        .async_in(mosi_in),
        .sync_out(mosi_sync)
    );

    spictl_sync #(.RESET_VAL(1'b0)) u_miso_sync (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .clk_en_in(clk_en_in),
        .async_in(miso_in),
        .sync_out(miso_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // register decode

    assign wr_ctl_one = bus_in.wr && (bus_in.addr == `SPICTL_ADDR_CTL_ONE);
    assign wr_ctl_two = bus_in.wr && (bus_in.addr == `SPICTL_ADDR_CTL_TWO);
    assign wr_bit_rate = bus_in.wr && (bus_in.addr == `SPICTL_ADDR_BIT_RATE);
    assign wr_evt_status = bus_in.wr && (bus_in.addr == `SPICTL_ADDR_EVT_STATUS);
    assign wr_evt_mask = bus_in.wr && (bus_in.addr == `SPICTL_ADDR_EVT_MASK);
    assign rd_status = bus_in.rd && (bus_in.addr == `SPICTL_ADDR_STATUS);

    assign is_master = ctl_one_reg.enable && ctl_one_reg.master_select;
    assign is_slave = ctl_one_reg.enable && !ctl_one_reg.master_select;
    // fault input only when the select pin is not an output
    assign fault_cond = is_master && ctl_two_reg.fault_detect_enable
                        && !ctl_one_reg.select_output_enable && !ss_sync; // [R14] [R15]
    assign halted = wait_mode_in && ctl_two_reg.halt_in_wait; // [R07]
    assign halt_event = halted && !wait_prev_reg;

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctl_one_reg <= spictl_ctl_one_s'(3'h0);
        end else if (clk_en_in && wr_ctl_one) begin
            ctl_one_reg.enable <= bus_in.wdata[`SPICTL_C1_ENABLE];
            ctl_one_reg.master_select <= bus_in.wdata[`SPICTL_C1_MASTER];
            ctl_one_reg.select_output_enable <= bus_in.wdata[`SPICTL_C1_SEL_OE];
        end
    end

    // unimplemented bit positions are never stored
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctl_two_reg <= spictl_ctl_two_s'(4'h0);
        end else if (clk_en_in && wr_ctl_two) begin
            ctl_two_reg.fault_detect_enable <= bus_in.wdata[`SPICTL_C2_FAULT_EN];
            ctl_two_reg.shared_pin_drive_enable <= bus_in.wdata[`SPICTL_C2_DRIVE_EN];
            ctl_two_reg.halt_in_wait <= bus_in.wdata[`SPICTL_C2_HALT_WAIT];
            ctl_two_reg.single_wire_select <= bus_in.wdata[`SPICTL_C2_SINGLE];
        end
    end

    // no busy gate: rate changes take effect on the next prescale count
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            bit_rate_reg <= spictl_rate_s'(6'h00);
        end else if (clk_en_in && wr_bit_rate) begin
            bit_rate_reg <= {bus_in.wdata[6:4], bus_in.wdata[2:0]}; // [R10]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fault flag: read it while set, then write control one; a new fault wins

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fault_flag_reg <= 1'b0;
            fault_armed_reg <= 1'b0;
        end else if (clk_en_in) begin
            if (fault_cond) begin
                fault_flag_reg <= 1'b1; // [R15]
            end else if (fault_armed_reg && wr_ctl_one) begin
                fault_flag_reg <= 1'b0;
            end
            if (rd_status && fault_flag_reg) begin
                fault_armed_reg <= 1'b1;
            end else if (wr_ctl_one || !fault_flag_reg) begin
                fault_armed_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // events, mask and interrupt

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            evt_status_reg <= `SPICTL_RST_EVT;
        end else if (clk_en_in) begin
            evt_status_reg <= (evt_status_reg & ~(wr_evt_status ? bus_in.wdata[1:0] : 2'h0))
                              | {halt_event, fault_cond};
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            evt_mask_reg <= `SPICTL_RST_EVT;
        end else if (clk_en_in && wr_evt_mask) begin
            evt_mask_reg <= bus_in.wdata[1:0];
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_out <= 1'b0;
            wait_prev_reg <= 1'b0;
        end else if (clk_en_in) begin
            irq_out <= |(evt_status_reg & evt_mask_reg);
            wait_prev_reg <= halted;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path

    assign ctl_two_view = {3'h0, ctl_two_reg.fault_detect_enable, ctl_two_reg.shared_pin_drive_enable,
                           1'b0, ctl_two_reg.halt_in_wait, ctl_two_reg.single_wire_select}; // [R01]
    assign bit_rate_view = {1'b0, bit_rate_reg.prescale_field, 1'b0, bit_rate_reg.rate_divisor_field};
    assign status_view = {rx_full_in, 1'b0, tx_empty_in, fault_flag_reg, 4'h0}; // [R13]

    always_comb begin
        rd_data_next = 8'h00;
        if (bus_in.rd) begin
            unique case (bus_in.addr)
                `SPICTL_ADDR_CTL_ONE: begin
                    rd_data_next[`SPICTL_C1_ENABLE] = ctl_one_reg.enable;
                    rd_data_next[`SPICTL_C1_MASTER] = ctl_one_reg.master_select;
                    rd_data_next[`SPICTL_C1_SEL_OE] = ctl_one_reg.select_output_enable;
                end
                `SPICTL_ADDR_CTL_TWO: rd_data_next = ctl_two_view;
                `SPICTL_ADDR_BIT_RATE: rd_data_next = bit_rate_view; // [R10]
                `SPICTL_ADDR_STATUS: rd_data_next = status_view;
                `SPICTL_ADDR_EVT_STATUS: rd_data_next = {6'h00, evt_status_reg};
                `SPICTL_ADDR_EVT_MASK: rd_data_next = {6'h00, evt_mask_reg};
                default: rd_data_next = 8'h00;
            endcase
        end
    end

    // data stand one cycle only
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rd_data_out <= 8'h00;
        end else if (clk_en_in) begin
            rd_data_out <= rd_data_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // baud generator: prescaler then power-of-two divider

    assign baud_run = is_master && !halted; // [R07]
    assign pre_wrap = (pre_cnt_reg == bit_rate_reg.prescale_field); // [R11]
    assign div_limit = (8'h01 << bit_rate_reg.rate_divisor_field) - 8'h01;
    // half period is 2^field prescaled ticks, so full period is 2^(field+1)
    assign div_wrap = (div_cnt_reg == div_limit[6:0]); // [R12]

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pre_cnt_reg <= 3'h0;
            div_cnt_reg <= 7'h00;
            bit_clk_out <= 1'b0;
            bit_tick_out <= 1'b0;
        end else if (clk_en_in) begin
            bit_tick_out <= 1'b0;
            if (!is_master) begin
                pre_cnt_reg <= 3'h0;
                div_cnt_reg <= 7'h00;
                bit_clk_out <= 1'b0;
            end else if (baud_run) begin
                if (pre_wrap) begin
                    pre_cnt_reg <= 3'h0; // [R11]
                    if (div_wrap) begin
                        div_cnt_reg <= 7'h00;
                        bit_clk_out <= !bit_clk_out; // [R16]
                        bit_tick_out <= 1'b1;
                    end else begin
                        div_cnt_reg <= div_cnt_reg + 7'h01; // [R12]
                    end
                end else begin
                    pre_cnt_reg <= pre_cnt_reg + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            clocks_running_out <= 1'b1;
        end else if (clk_en_in) begin
            clocks_running_out <= !halted; // [R07]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin steering

    always_comb begin
        ss_pin_next = '{level: 1'b1, oe_n: 1'b1};
        gpio_release_next = 1'b1;
        selected_next = 1'b0;
        if (is_slave) begin
            gpio_release_next = 1'b0;
            selected_next = !ss_sync; // [R02]
        end else if (is_master && ctl_two_reg.fault_detect_enable) begin
            gpio_release_next = 1'b0; // [R04]
            if (ctl_one_reg.select_output_enable) begin
                ss_pin_next = '{level: !transfer_active_in, oe_n: 1'b0}; // [R14]
            end
        end else if (is_master) begin
            gpio_release_next = 1'b1; // [R03]
        end
    end

    always_comb begin
        mosi_pin_next = '{level: 1'b0, oe_n: 1'b1};
        miso_pin_next = '{level: 1'b0, oe_n: 1'b1};
        rx_bit_next = 1'b0;
        if (ctl_two_reg.single_wire_select) begin
            if (is_master) begin
                mosi_pin_next = '{level: shift_data_in, oe_n: !ctl_two_reg.shared_pin_drive_enable}; // [R05] [R08]
                rx_bit_next = mosi_sync;
            end else if (is_slave) begin
                // a deselected slave never drives the shared wire
                miso_pin_next = '{level: shift_data_in,
                                  oe_n: !(ctl_two_reg.shared_pin_drive_enable && !ss_sync)}; // [R05] [R08]
                rx_bit_next = miso_sync;
            end
        end else begin
            // drive enable bit is not consulted on this path
            if (is_master) begin
                mosi_pin_next = '{level: shift_data_in, oe_n: 1'b0}; // [R06] [R09]
                rx_bit_next = miso_sync;
            end else if (is_slave) begin
                miso_pin_next = '{level: shift_data_in, oe_n: ss_sync}; // [R06] [R09]
                rx_bit_next = mosi_sync;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ss_pin_out <= '{level: 1'b1, oe_n: 1'b1};
            mosi_pin_out <= '{level: 1'b0, oe_n: 1'b1};
            miso_pin_out <= '{level: 1'b0, oe_n: 1'b1};
            ss_gpio_release_out <= 1'b1;
            slave_selected_out <= 1'b0;
            rx_bit_out <= 1'b0;
        end else if (clk_en_in) begin
            ss_pin_out <= ss_pin_next;
            mosi_pin_out <= mosi_pin_next;
            miso_pin_out <= miso_pin_next;
            ss_gpio_release_out <= gpio_release_next;
            slave_selected_out <= selected_next;
            rx_bit_out <= rx_bit_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);

    logic [12:0] gap_cnt_reg;
    logic gap_valid_reg;
    logic [12:0] half_period;
    assign half_period = 13'({10'h000, bit_rate_reg.prescale_field} + 13'h0001) << bit_rate_reg.rate_divisor_field;

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            gap_cnt_reg <= 13'h0000;
            gap_valid_reg <= 1'b0;
        end else if (clk_en_in) begin
            if (!baud_run || wr_bit_rate || wr_ctl_one || wr_ctl_two) begin
                gap_valid_reg <= 1'b0;
                gap_cnt_reg <= 13'h0000;
            end else if (bit_tick_out) begin
                gap_valid_reg <= 1'b1;
                gap_cnt_reg <= 13'h0001;
            end else begin
                gap_cnt_reg <= gap_cnt_reg + 13'h0001;
            end
        end
    end

    a_ctl_two_reserved: assert property (clk_en_in && bus_in.rd && bus_in.addr == `SPICTL_ADDR_CTL_TWO // [R01]
        |=> rd_data_out[7:5] == 3'h0 && rd_data_out[2] == 1'b0)
        else $error("reserved control two bits read nonzero");
    a_status_reserved: assert property (clk_en_in && rd_status // [R13]
        |=> rd_data_out[6] == 1'b0 && rd_data_out[3:0] == 4'h0)
        else $error("reserved status bits read nonzero");
    a_status_write_inert: assert property (clk_en_in && bus_in.wr && bus_in.addr == `SPICTL_ADDR_STATUS // [R13]
        && !fault_cond |=> fault_flag_reg == $past(fault_flag_reg))
        else $error("status write changed the fault flag");
    a_slave_ss_input: assert property (clk_en_in && is_slave |=> ss_pin_out.oe_n && !ss_gpio_release_out) // [R02]
        else $error("slave drives or releases the select pin");
    a_master_gpio_release: assert property (clk_en_in && is_master && !ctl_two_reg.fault_detect_enable // [R03]
        |=> ss_gpio_release_out && ss_pin_out.oe_n)
        else $error("select pin not released to general use");
    a_auto_select_out: assert property (clk_en_in && is_master && ctl_two_reg.fault_detect_enable // [R14]
        && ctl_one_reg.select_output_enable |=> !ss_pin_out.oe_n && !ss_gpio_release_out)
        else $error("automatic select output not driven");
    a_fault_flag_set: assert property (clk_en_in && fault_cond |=> fault_flag_reg) // [R15]
        else $error("fault flag not set on select low");
    a_bidir_master_pin: assert property (clk_en_in && is_master && ctl_two_reg.single_wire_select // [R05]
        |=> mosi_pin_out.oe_n == !$past(ctl_two_reg.shared_pin_drive_enable) && miso_pin_out.oe_n)
        else $error("master shared pin drive wrong");
    a_separate_pins: assert property (clk_en_in && is_master && !ctl_two_reg.single_wire_select // [R09]
        |=> !mosi_pin_out.oe_n && miso_pin_out.oe_n)
        else $error("separate pin drive wrong");
    a_wait_halt: assert property (clk_en_in && halted |=> !clocks_running_out && !bit_tick_out) // [R07]
        else $error("clocks not stopped in wait");
    a_bit_period: assert property (clk_en_in && bit_tick_out && gap_valid_reg // [R16]
        |-> gap_cnt_reg == half_period)
        else $error("bit clock half period wrong");

endmodule

//--- test/spictl_peer.sv
// far-side model: peer holding the select line and the two data lines
`timescale 1ns/10ps
module spictl_peer (
    input wire logic sys_clk_in,
    input wire logic sel_low_in,
    input wire spictl_pkg::spictl_pin_s ss_pin_in,
    input wire spictl_pkg::spictl_pin_s mosi_pin_in,
    input wire spictl_pkg::spictl_pin_s miso_pin_in,
    output logic ss_out,
    output logic mosi_out,
    output logic miso_out
);
    import spictl_pkg::*;
    logic toggle_reg = 1'b0;
    // undriven data lines wander every cycle so a stale level never passes
    always_ff @(posedge sys_clk_in) begin
        toggle_reg <= ~toggle_reg;
    end
    assign ss_out = ss_pin_in.oe_n ? ~sel_low_in : ss_pin_in.level;
    assign mosi_out = mosi_pin_in.oe_n ? toggle_reg : mosi_pin_in.level;
    assign miso_out = miso_pin_in.oe_n ? ~toggle_reg : miso_pin_in.level;
endmodule

//--- test/tb.sv
// self-checking bench for the serial control block
`timescale 1ns/10ps
module tb;
    import spictl_pkg::*;
    logic sys_clk_in, arst_n_in, wm, rxf, txe, xfer, sd, sel_low, rd_seen, irq, sel, tick, run, gpio, ss_w, mo_w, mi_w;
    logic [7:0] rdd, v;
    logic en, bclk;
    logic [31:0] seed;
    logic [7:0] exp_q[$];
    spictl_bus_s bus;
    spictl_pin_s ss_p, mo_p, mi_p;
    int errors, check_count, i;
    spictl_top spictl_top_i (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .clk_en_in(en), .bus_in(bus),
        .rd_data_out(rdd), .irq_out(irq), .wait_mode_in(wm), .rx_full_in(rxf), .tx_empty_in(txe),
        .transfer_active_in(xfer), .shift_data_in(sd), .rx_bit_out(), .slave_selected_out(sel), .bit_clk_out(bclk),
        .bit_tick_out(tick), .clocks_running_out(run), .ss_gpio_release_out(gpio), .ss_in(ss_w), .ss_pin_out(ss_p),
        .mosi_in(mo_w), .mosi_pin_out(mo_p), .miso_in(mi_w), .miso_pin_out(mi_p));
    spictl_peer spictl_peer_i (.sys_clk_in(sys_clk_in), .sel_low_in(sel_low), .ss_pin_in(ss_p), .mosi_pin_in(mo_p),
        .miso_pin_in(mi_p), .ss_out(ss_w), .mosi_out(mo_w), .miso_out(mi_w));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk_in) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk_in) bus <= '0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge sys_clk_in) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk_in) bus <= '0;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask
    // settles on the second full tick spacing, so a mid-count rate change is skipped
    task automatic gap(input logic [15:0] e);
        int n;
        for (int k = 0; k < 3; k++) begin
            @(posedge sys_clk_in);
            n = 1;
            while (tick !== 1'b1 && n < 5000) begin
                @(posedge sys_clk_in);
                n++;
            end
        end
        chk("tick_gap", e, n[15:0]);
    endtask
    task automatic final_report();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk_in) begin
        if (rd_seen) begin
            chk("rd_data", exp_q.pop_front(), rdd);
        end else begin
            chk("rd_idle", 8'h00, rdd);
        end
        rd_seen <= bus.rd;
        seed <= lfsr(seed);
        sd <= seed[3];
    end
    initial begin
        sys_clk_in = 1'b0;
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end
    initial begin
        #400000;
        errors++;
        final_report();
    end
    initial begin
        {arst_n_in, wm, rxf, txe, xfer, sd, sel_low, rd_seen} = '0;
        bus = '0;
        en = 1'b1;
        seed = 32'h6C1414ED;
        cyc(16);
        arst_n_in <= 1'b1;
        rd(3'h1, 8'h00);
        rd(3'h2, 8'h00);
        wr(3'h1, 8'hFF);
        rd(3'h1, 8'h1B);
        wr(3'h3, 8'hFF);
        rxf <= 1'b1;
        txe <= 1'b1;
        rd(3'h3, 8'hA0);
        rd(3'h7, 8'h00);
        wr(3'h1, 8'h00);
        wr(3'h0, 8'h50);
        for (i = 0; i < 5; i++) begin
            v = i == 0 ? 8'h00 : (i == 1 ? 8'hFF : seed[7:0]);
            wr(3'h2, v);
            rd(3'h2, v & 8'h77);
            gap(16'({1'b0, v[6:4]} + 4'h1) << v[2:0]);
        end
        wr(3'h2, 8'h10);
        wr(3'h1, 8'h02);
        wm <= 1'b1;
        cyc(3);
        chk("clocks_run", 1'b0, run);
        rd(3'h4, 8'h02);
        wr(3'h4, 8'h02);
        rd(3'h4, 8'h00);
        wr(3'h1, 8'h00);
        cyc(3);
        chk("clocks_run", 1'b1, run);
        wm <= 1'b0;
        chk("ss_gpio", 1'b1, gpio);
        wr(3'h1, 8'h10);
        wr(3'h0, 8'h52);
        xfer <= 1'b1;
        cyc(3);
        chk("ss_pin", 2'b00, {ss_p.level, ss_p.oe_n});
        wr(3'h0, 8'h50);
        wr(3'h5, 8'h01);
        sel_low <= 1'b1;
        cyc(8);
        rd(3'h3, 8'hB0);
        chk("irq", 1'b1, irq);
        sel_low <= 1'b0;
        cyc(8);
        wr(3'h0, 8'h50);
        wr(3'h4, 8'h01);
        cyc(3);
        rd(3'h3, 8'hA0);
        chk("irq", 1'b0, irq);
        wr(3'h1, 8'h08);
        cyc(3);
        chk("sep_pins", 2'b01, {mo_p.oe_n, mi_p.oe_n});
        wr(3'h1, 8'h09);
        cyc(3);
        chk("single_on", 2'b01, {mo_p.oe_n, mi_p.oe_n});
        wr(3'h1, 8'h01);
        cyc(3);
        chk("single_off", 2'b11, {mo_p.oe_n, mi_p.oe_n});
        wr(3'h0, 8'h40);
        wr(3'h1, 8'h10);
        sel_low <= 1'b1;
        cyc(8);
        chk("slave_sel", 4'b1000, {sel, gpio, mi_p.oe_n, bclk});
        wr(3'h1, 8'h19);
        cyc(3);
        chk("slave_single", 2'b10, {mo_p.oe_n, mi_p.oe_n});
        en <= 1'b0;
        wr(3'h1, 8'h00);
        en <= 1'b1;
        rd(3'h1, 8'h19);
        cyc(2);
        final_report();
    end
endmodule
